/* pkg/adcc_pkg.sv */
/*
 * adcc_pkg: shared constants, register map, field positions and carrier
 * types of the converter control block.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
package adcc_pkg;

    // ------------------------------------------------------------------
    // register map (index; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CONV_CONTROL = 8'hb8;
    localparam logic [7:0] IDX_TRIG_FLAG_CONTROL = 8'hb9;
    localparam logic [7:0] IDX_RESULT_LOW = 8'hba;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'hbb;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hbc;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hbd;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTL_START_BIT = 0;
    localparam int CTL_IRQ_EN_BIT = 1;
    localparam int TFC_CONV_DONE_BIT = 0;
    localparam int TFC_PWM_DONE_BIT = 4;
    localparam int TFC_TIMER_DONE_BIT = 6;
    localparam int EVT_CONV_DONE_BIT = 0;
    localparam int EVT_TIMER_BIT = 1;
    localparam int EVT_PWM_BIT = 2;
    localparam int EVT_IGNORED_BIT = 3;
    localparam int EVT_WIDTH = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CONV_CONTROL_RST = 8'h00;
    localparam logic [7:0] TRIG_FLAG_CONTROL_RST = 8'h00;
    localparam logic [EVT_WIDTH-1:0] IRQ_STATUS_RST = 4'h0;
    localparam logic [EVT_WIDTH-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [1:0] AVG_RST = 2'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // control register layout: avg[7:6] chan[5:4] sh[3:2] irq_en[1] start[0]
    typedef struct packed {
        logic [1:0] average_count_sel;
        logic [1:0] chan_sel;
        logic [1:0] sample_hold_time_sel;
        logic irq_en;
        logic sw_conv_start;
    } adcc_ctrl_t;

    // request to the analog converter core
    typedef struct packed {
        logic start;
        logic [1:0] chan_sel;
        logic [1:0] sample_hold_time_sel;
    } adcc_core_req_t;

    // answer from the analog converter core
    typedef struct packed {
        logic done;
        logic [11:0] sample;
    } adcc_core_rsp_t;

    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_START = 3'b010,
        ADCC_WAIT = 3'b100
    } adcc_state_t;

endpackage

/* design/adcc_sticky.sv */
/*
 * adcc_sticky: bank of sticky flags, set by hardware, cleared by request.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/100ps
module adcc_sticky #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags_q
);

    // ------------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] flags_d;

    // a set in the clearing cycle wins
    assign flags_d = (flags_q & ~clr) | set;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flags_q <= RST_VAL;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

endmodule // adcc_sticky

/* design/adcc_avg_acc.sv */
/*
 * adcc_avg_acc: sums 1, 2, 4 or 8 samples and delivers their mean.
 * Assumes one sample_valid pulse per finished core conversion.
 */
`timescale 1ns/100ps
module adcc_avg_acc #(
    parameter int SAMPLE_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic [1:0] avg_sel,
    output logic last,
    output logic [SAMPLE_W-1:0] mean
);

    // ------------------------------------------------------------------
    // accumulation
    // ------------------------------------------------------------------
    logic [SAMPLE_W+2:0] acc_q;
    logic [SAMPLE_W+2:0] acc_d;
    logic [SAMPLE_W+2:0] sum;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] target;

    // number of samples minus one
    assign target = 3'((4'h1 << avg_sel) - 4'h1);
    assign sum = acc_q + {3'h0, sample};
    assign last = sample_valid && (cnt_q == target);
    assign mean = SAMPLE_W'(sum >> avg_sel);
    assign acc_d = (clear || last) ? '0 : (sample_valid ? sum : acc_q);
    assign cnt_d = (clear || last) ? 3'h0 : (sample_valid ? cnt_q + 3'h1 : cnt_q);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            acc_q <= '0;
            cnt_q <= 3'h0;
        end
        else
        begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
        end
    end

endmodule // adcc_avg_acc

/* design/adcc_conv_ctrl.sv */
/*
 * adcc_conv_ctrl: control and status of the on-chip 12-bit converter,
 * reached by software over APB; issues conversion requests to the analog
 * core, averages its samples and reports completion by flags and interrupt.
 * Assumes the analog core and the timer and PWM trigger sources run on clk,
 * and that the core answers each start with one done pulse.
 */
// Functional notes
// - busy reads 1 for the whole time a conversion is in progress.
// - writing 1 to start begins conversion; hardware clears start when done.
// - timer trigger sets its done flag; software clear; cleared with irq flag.
// - pwm trigger sets its done flag; software clear; cleared with irq flag.
// - conversion done flag at bit 0 of trigger register set at each finish.
// - with interrupt enabled, the done flag also raises the interrupt request.
// - only software clears the done flag; clearing it clears all register flags.
// - result low and high bytes are read only; writes ignored; no reset value.
// - starts or triggers during a conversion are ignored; current one continues.
// - two-bit field averages 1, 2, 4 or 8 samples; default 00.
`timescale 1ns/100ps
module adcc_conv_ctrl #(
    parameter int SAMPLE_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // hardware triggers
    input wire logic timer_trig,
    input wire logic pwm_trig,
    // analog converter core
    output adcc_pkg::adcc_core_req_t core_req,
    input wire adcc_pkg::adcc_core_rsp_t core_rsp,
    output logic [1:0] average_count_sel,
    output logic busy,
    output logic irq
);

    // ------------------------------------
    // declarations
    // ------------------------------------
    adcc_pkg::adcc_state_t state_q;
    adcc_pkg::adcc_state_t state_d;
    adcc_pkg::adcc_ctrl_t ctrl_q;
    adcc_pkg::adcc_ctrl_t ctrl_d;
    logic [7:0] result_low_byte_q;
    logic [7:0] result_high_byte_q;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [7:0] trig_flags_q;
    logic [adcc_pkg::EVT_WIDTH-1:0] evt_set;
    logic [adcc_pkg::EVT_WIDTH-1:0] evt_clr;
    logic [adcc_pkg::EVT_WIDTH-1:0] evt_q;
    logic [adcc_pkg::EVT_WIDTH-1:0] mask_q;
    logic [adcc_pkg::EVT_WIDTH-1:0] mask_d;
    logic access;
    logic wr_en;
    logic lane0;
    logic sel_ctrl, sel_flags, sel_low, sel_high, sel_stat, sel_mask;
    logic mapped;
    logic sw_start_req;
    logic any_request;
    logic launch, ignored, finish, last;
    logic [SAMPLE_W-1:0] mean;
    logic [7:0] wbyte;
    logic conv_done_irq_flag;
    logic irq_flag_cleared;

    // ------------------------------------
    // address decode
    // ------------------------------------
    // true when the word address matches a register index
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
    endfunction

    // apb decode; registers answer with no wait state
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign lane0 = pstrb[0];
    assign wbyte = pwdata[7:0];
    assign sel_ctrl = hit(paddr, adcc_pkg::IDX_CONV_CONTROL);
    assign sel_flags = hit(paddr, adcc_pkg::IDX_TRIG_FLAG_CONTROL);
    assign sel_low = hit(paddr, adcc_pkg::IDX_RESULT_LOW);
    assign sel_high = hit(paddr, adcc_pkg::IDX_RESULT_HIGH);
    assign sel_stat = hit(paddr, adcc_pkg::IDX_IRQ_STATUS);
    assign sel_mask = hit(paddr, adcc_pkg::IDX_IRQ_MASK);
    assign mapped = sel_ctrl | sel_flags | sel_low | sel_high | sel_stat | sel_mask;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ------------------------------------
    // read data
    // ------------------------------------
    // control word reads busy in place of the start bit
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (sel_ctrl)
        begin
            prdata[7:0] = {ctrl_q[7:1], busy};
        end
        else if (sel_flags)
        begin
            prdata[7:0] = trig_flags_q;
        end
        else if (sel_low)
        begin
            prdata[7:0] = result_low_byte_q;
        end
        else if (sel_high)
        begin
            prdata[7:0] = result_high_byte_q;
        end
        else if (sel_stat)
        begin
            prdata[adcc_pkg::EVT_WIDTH-1:0] = evt_q;
        end
        else if (sel_mask)
        begin
            prdata[adcc_pkg::EVT_WIDTH-1:0] = mask_q;
        end
    end

    // ------------------------------------
    // start arbitration
    // ------------------------------------
    // software start is a write of 1 to the start bit
    assign sw_start_req = wr_en && sel_ctrl && lane0 && wbyte[adcc_pkg::CTL_START_BIT];
    assign any_request = sw_start_req | timer_trig | pwm_trig;
    // only an idle converter accepts a request
    assign launch = any_request && (state_q == adcc_pkg::ADCC_IDLE);
    assign ignored = any_request && (state_q != adcc_pkg::ADCC_IDLE);
    assign busy = (state_q != adcc_pkg::ADCC_IDLE);
    assign finish = last && (state_q == adcc_pkg::ADCC_WAIT);

    // ------------------------------------
    // conversion sequencer
    // ------------------------------------
    // one core start per averaged sample, repeat until the set is full
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            adcc_pkg::ADCC_IDLE:
            begin
                if (launch)
                begin
                    state_d = adcc_pkg::ADCC_START;
                end
            end
            adcc_pkg::ADCC_START:
            begin
                state_d = adcc_pkg::ADCC_WAIT;
            end
            adcc_pkg::ADCC_WAIT:
            begin
                if (finish)
                begin
                    state_d = adcc_pkg::ADCC_IDLE;
                end
                else if (core_rsp.done)
                begin
                    state_d = adcc_pkg::ADCC_START;
                end
            end
            default:
            begin
                state_d = adcc_pkg::ADCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= adcc_pkg::ADCC_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // core request carries the live channel and sample-hold settings
    assign core_req.start = (state_q == adcc_pkg::ADCC_START);
    assign core_req.chan_sel = ctrl_q.chan_sel;
    assign core_req.sample_hold_time_sel = ctrl_q.sample_hold_time_sel;
    assign average_count_sel = ctrl_q.average_count_sel;

    // ------------------------------------
    // averaging
    // ------------------------------------
    adcc_avg_acc #(
        .SAMPLE_W(SAMPLE_W)
    ) u_avg (
        .clk(clk),
        .reset(reset),
        .clear(launch),
        .sample_valid(core_rsp.done && (state_q == adcc_pkg::ADCC_WAIT)),
        .sample(core_rsp.sample),
        .avg_sel(ctrl_q.average_count_sel),
        .last(last),
        .mean(mean)
    );

    // ------------------------------------
    // control register
    // ------------------------------------
    // start bit self-clears when the conversion finishes
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_en && sel_ctrl && lane0)
        begin
            ctrl_d[7:1] = wbyte[7:1];
        end
        if (launch && sw_start_req)
        begin
            ctrl_d.sw_conv_start = 1'b1;
        end
        else if (finish)
        begin
            ctrl_d.sw_conv_start = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_q <= adcc_pkg::CONV_CONTROL_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------
    // result bytes
    // ------------------------------------
    // loaded together with the done flag; no reset, writes never reach them
    always_ff @(posedge clk)
    begin
        if (finish)
        begin
            result_low_byte_q <= mean[7:0];
            result_high_byte_q <= 8'(mean[SAMPLE_W-1:8]);
        end
    end

    // ------------------------------------
    // trigger flag control register
    // ------------------------------------
    // software writes 0 to clear a flag; clearing the irq flag clears all
    assign irq_flag_cleared = wr_en && sel_flags && lane0
        && !wbyte[adcc_pkg::TFC_CONV_DONE_BIT] && conv_done_irq_flag;
    always_comb
    begin
        flag_set = 8'h00;
        flag_clr = 8'h00;
        flag_set[adcc_pkg::TFC_TIMER_DONE_BIT] = launch && timer_trig;
        flag_set[adcc_pkg::TFC_PWM_DONE_BIT] = launch && pwm_trig;
        flag_set[adcc_pkg::TFC_CONV_DONE_BIT] = finish;
        if (wr_en && sel_flags && lane0)
        begin
            flag_clr[adcc_pkg::TFC_TIMER_DONE_BIT] =
                !wbyte[adcc_pkg::TFC_TIMER_DONE_BIT];
            flag_clr[adcc_pkg::TFC_PWM_DONE_BIT] = !wbyte[adcc_pkg::TFC_PWM_DONE_BIT];
            flag_clr[adcc_pkg::TFC_CONV_DONE_BIT] =
                !wbyte[adcc_pkg::TFC_CONV_DONE_BIT];
        end
        if (irq_flag_cleared)
        begin
            flag_clr = 8'hff;
        end
    end

    adcc_sticky #(
        .WIDTH(8),
        .RST_VAL(adcc_pkg::TRIG_FLAG_CONTROL_RST)
    ) u_trig_flags (
        .clk(clk),
        .reset(reset),
        .set(flag_set),
        .clr(flag_clr),
        .flags_q(trig_flags_q)
    );

    assign conv_done_irq_flag = trig_flags_q[adcc_pkg::TFC_CONV_DONE_BIT];

    // ------------------------------------
    // event status and mask
    // ------------------------------------
    // sticky events, write one to clear
    always_comb
    begin
        evt_set = '0;
        evt_set[adcc_pkg::EVT_CONV_DONE_BIT] = finish;
        evt_set[adcc_pkg::EVT_TIMER_BIT] = launch && timer_trig;
        evt_set[adcc_pkg::EVT_PWM_BIT] = launch && pwm_trig;
        evt_set[adcc_pkg::EVT_IGNORED_BIT] = ignored;
        evt_clr = '0;
        if (wr_en && sel_stat && lane0)
        begin
            evt_clr = wbyte[adcc_pkg::EVT_WIDTH-1:0];
        end
    end

    adcc_sticky #(
        .WIDTH(adcc_pkg::EVT_WIDTH),
        .RST_VAL(adcc_pkg::IRQ_STATUS_RST)
    ) u_events (
        .clk(clk),
        .reset(reset),
        .set(evt_set),
        .clr(evt_clr),
        .flags_q(evt_q)
    );

    assign mask_d = (wr_en && sel_mask && lane0) ? wbyte[adcc_pkg::EVT_WIDTH-1:0] : mask_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mask_q <= adcc_pkg::IRQ_MASK_RST;
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------
    // interrupt
    // ------------------------------------
    // done flag with enable, or any unmasked sticky event
    assign irq = (conv_done_irq_flag && ctrl_q.irq_en) || (|(evt_q & mask_q));

endmodule // adcc_conv_ctrl

/* verif/adcc_core_model.sv */
/*
 * adcc_core_model: analog converter core seen from the control block.
 * Assumes one start pulse per sample on clk; answer time set by delay (>= 1).
 */
`timescale 1ns/100ps
module adcc_core_model (
    input wire logic clk,
    input wire logic reset,
    input wire adcc_pkg::adcc_core_req_t core_req,
    input wire logic [7:0] delay,
    input wire logic [11:0] base,
    output adcc_pkg::adcc_core_rsp_t core_rsp
);
    // ------------------------------------------------------------
    // sample timing
    // ------------------------------------------------------------
    logic [7:0] cnt_q;
    logic [11:0] idx_q;
    logic [11:0] last_q;
    logic done_q;
    // each start loads the counter; one done pulse when it expires
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            idx_q <= 12'h000;
            last_q <= 12'h000;
        end
        else
        begin
            done_q <= 1'b0;
            if (core_req.start)
                cnt_q <= delay;
            else if (cnt_q != 8'h00)
            begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01)
                begin
                    done_q <= 1'b1;
                    last_q <= base + idx_q;
                    idx_q <= idx_q + 12'h001;
                end
            end
        end
    end
    // sample only valid with done; inverted otherwise so stale use shows
    assign core_rsp.done = done_q;
    assign core_rsp.sample = done_q ? last_q : ~last_q;
endmodule // adcc_core_model

/* verif/adcc_conv_ctrl_asserts.sv */
/*
 * adcc_conv_ctrl_asserts: port checks of the converter control block.
 * Assumes it is bound to adcc_conv_ctrl; one clock, synchronous reset.
 */
`timescale 1ns/100ps
module adcc_conv_ctrl_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_trig,
    input wire logic pwm_trig,
    input wire adcc_pkg::adcc_core_req_t core_req,
    input wire adcc_pkg::adcc_core_rsp_t core_rsp,
    input wire logic [1:0] average_count_sel,
    input wire logic busy,
    input wire logic irq
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // committed control write and any trigger
    wire wr_ctl = psel && penable && pwrite && pstrb[0] && paddr == 12'h2e0;
    wire trig = timer_trig || pwm_trig;
    property p_start_busy;
        core_req.start |-> busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("core start without busy");
    property p_busy_hold;
        busy && !core_rsp.done |=> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped without done");
    property p_fall_done;
        $fell(busy) |-> $past(core_rsp.done);
    endproperty
    a_fall_done: assert property (p_fall_done)
        else $error("busy fell not after done");
    property p_sw_start;
        wr_ctl && pwdata[0] && !busy |=> busy && core_req.start;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start not taken");
    property p_trig_take;
        trig && !busy |=> core_req.start ##1 (!core_req.start && busy);
    endproperty
    a_trig_take: assert property (p_trig_take)
        else $error("trigger not taken");
    property p_ignore;
        busy && !core_rsp.done && (trig || wr_ctl) |=> busy;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("request during conversion disturbed it");
    property p_avg_stable;
        !wr_ctl |=> $stable(average_count_sel);
    endproperty
    a_avg_stable: assert property (p_avg_stable)
        else $error("averaging select changed");
    property p_avg_write;
        wr_ctl |=> average_count_sel == $past(pwdata[7:6]);
    endproperty
    a_avg_write: assert property (p_avg_write)
        else $error("averaging select not written");
    // main scenarios
    c_done: cover property ($fell(busy));
    c_busy_trig: cover property (busy && trig);
    c_irq: cover property ($rose(irq));
endmodule // adcc_conv_ctrl_asserts

bind adcc_conv_ctrl adcc_conv_ctrl_asserts u_adcc_conv_ctrl_asserts (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trig(timer_trig), .pwm_trig(pwm_trig),
    .core_req(core_req), .core_rsp(core_rsp),
    .average_count_sel(average_count_sel), .busy(busy), .irq(irq));

/* verif/adcc_conv_ctrl_tb_top.sv */
/*
 * adcc_conv_ctrl_tb_top: self-checking bench of the converter control.
 * Assumes APB with no wait states and the core model answering each start.
 */
`timescale 1ns/100ps
module adcc_conv_ctrl_tb_top;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam logic [11:0] A_CTL = {2'b00, adcc_pkg::IDX_CONV_CONTROL, 2'b00};
    localparam logic [11:0] A_TFC = {2'b00, adcc_pkg::IDX_TRIG_FLAG_CONTROL, 2'b00};
    localparam logic [11:0] A_LO = {2'b00, adcc_pkg::IDX_RESULT_LOW, 2'b00};
    localparam logic [11:0] A_HI = {2'b00, adcc_pkg::IDX_RESULT_HIGH, 2'b00};
    localparam logic [11:0] A_ST = {2'b00, adcc_pkg::IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {2'b00, adcc_pkg::IDX_IRQ_MASK, 2'b00};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_trig = 1'b0, pwm_trig = 1'b0;
    logic [11:0] paddr = 12'h000, base = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, busy, irq, err;
    logic [7:0] delay = 8'h10;
    logic [1:0] average_count_sel;
    logic [15:0] lfsr = 16'h0053;
    adcc_pkg::adcc_core_req_t core_req;
    adcc_pkg::adcc_core_rsp_t core_rsp;
    int n_errors = 0, n_tests = 0, acc = 0, n_done = 0, n_start = 0, k;
    always #5 clk = ~clk;
    adcc_conv_ctrl u_adcc_conv_ctrl (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_trig(timer_trig), .pwm_trig(pwm_trig), .core_req(core_req),
        .core_rsp(core_rsp), .average_count_sel(average_count_sel), .busy(busy),
        .irq(irq));
    adcc_core_model u_adcc_core_model (.clk(clk), .reset(reset), .core_req(core_req),
        .delay(delay), .base(base), .core_rsp(core_rsp));
    // reference model: sum of samples delivered, count of samples and starts
    always @(posedge clk)
    begin
        if (core_rsp.done === 1'b1)
        begin
            acc = acc + core_rsp.sample;
            n_done++;
        end
        if (core_req.start === 1'b1)
            n_start++;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge clk);
            if (busy === 1'b0)
                break;
        end
        if (i == 2000)
        begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic pulse(input logic t);
        @(posedge clk);
        timer_trig <= t;
        pwm_trig <= !t;
        @(posedge clk);
        timer_trig <= 1'b0;
        pwm_trig <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rdc("ctl", A_CTL, 32'h0);
        rdc("tfc", A_TFC, 32'h0);
        rdc("status", A_ST, 32'h0);
        rdc("mask", A_MSK, 32'h0);
        // software start for every averaging count, with requests while busy
        for (k = 0; k < 4; k++)
        begin
            lfsr = lfsr_next(lfsr);
            base <= lfsr[11:0];
            delay <= 8'h10 + {5'h00, lfsr[14:12]};
            acc = 0;
            n_done = 0;
            n_start = 0;
            apb(A_CTL, 1'b1, {24'h0, k[1:0], lfsr[3:0], 2'b11});
            rdc("busy", A_CTL, {24'h0, k[1:0], lfsr[3:0], 2'b11});
            chk("chan", core_req[3:0], lfsr[3:0]);
            apb(A_CTL, 1'b1, {24'h0, k[1:0], lfsr[3:0], 2'b11});
            pulse(1'b0);
            wait_idle();
            apb(A_LO, 1'b1, 32'hff);
            apb(A_HI, 1'b1, 32'hff);
            chk("samples", n_done, 32'h1 << k);
            chk("starts", n_start, 32'h1 << k);
            rdc("lo", A_LO, (acc >> k) & 32'hff);
            rdc("hi", A_HI, (acc >> (k + 8)) & 32'hf);
            rdc("ctl", A_CTL, {24'h0, k[1:0], lfsr[3:0], 2'b10});
            rdc("tfc", A_TFC, 32'h01);
            chk("irq", irq, 32'h1);
            rdc("status", A_ST, 32'h9);
            apb(A_ST, 1'b1, 32'hf);
            apb(A_TFC, 1'b1, 32'h0);
            rdc("tfc", A_TFC, 32'h0);
            chk("irq", irq, 32'h0);
        end
        // timer, pwm, timer triggers answered promptly; clear one flag, then all
        for (k = 0; k < 3; k++)
        begin
            delay <= 8'h01;
            pulse(k != 1);
            wait_idle();
            rdc("tfc", A_TFC, (k == 1) ? 32'h11 : 32'h41);
            apb(A_TFC, 1'b1, (k < 2) ? 32'h01 : 32'h00);
            rdc("tfc", A_TFC, (k < 2) ? 32'h01 : 32'h00);
        end
        // status interrupt: masked, unmasked, cleared
        apb(A_CTL, 1'b1, 32'h0);
        rdc("status", A_ST, 32'h7);
        chk("irq", irq, 32'h0);
        apb(A_MSK, 1'b1, 32'h1);
        @(posedge clk);
        chk("irq", irq, 32'h1);
        apb(A_ST, 1'b1, 32'h1);
        @(posedge clk);
        chk("irq", irq, 32'h0);
        apb(12'h000, 1'b0, 32'h0);
        chk("slverr", err, 32'h1);
        give_verdict();
    end
endmodule // adcc_conv_ctrl_tb_top
